// [common/sdrtg_pkg.sv]
// Package of constants and types for the SDRAM power-state timing guard
package sdrtg_pkg;

  // ****************************************************************
  // Clock and conversion
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int CNT_W         = 16;
  localparam int CLKRUN_W      = 4;

  function automatic int ns_to_nck(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction : ns_to_nck

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : imax

  // ****************************************************************
  // Fixed timing terms
  // ****************************************************************
  localparam int MODE_WRITE_UPDATE_MIN_NCK    = 24;
  localparam int MODE_WRITE_UPDATE_MIN_NS     = 15;
  localparam int COMMAND_PASS_DISABLE_NCK     = 4;
  localparam int CLKEN_PULSE_MIN_NCK          = 3;
  localparam int CLKEN_PULSE_MIN_NS           = 5;
  localparam int CLKEN_SELFREF_EXTRA_NCK      = 1;
  localparam int CLOCK_VALID_MIN_NCK          = 5;
  localparam int CLOCK_VALID_MIN_NS           = 10;
  localparam int REFRESH_MARGIN_NS            = 10;
  localparam int RESET_EXIT_MIN_NCK           = 5;
  localparam int INITIAL_IMPEDANCE_CAL_TIME   = 1024;
  localparam int LONG_IMPEDANCE_CAL_TIME      = 512;
  localparam int SHORT_IMPEDANCE_CAL_TIME     = 128;

  // Timer reload is shortened by this to absorb the output register stages
  localparam logic [CNT_W-1:0] TMR_LOAD_ADJ   = 16'h0002;

  // ****************************************************************
  // Timer slots
  // ****************************************************************
  localparam int TI_ANY    = 0;
  localparam int TI_UNL    = 1;
  localparam int TI_LCK    = 2;
  localparam int TI_FAST   = 3;
  localparam int TI_CLKV   = 4;
  localparam int TI_CKESR  = 5;
  localparam int NUM_TMR   = 6;

  typedef enum logic [4:0] {
    ST_INIT    = 5'h01,
    ST_ACTIVE  = 5'h02,
    ST_SELFREF = 5'h04,
    ST_PWRDN   = 5'h08,
    ST_MAX_POWER_SAVING_MODE    = 5'h10
  } sdrtg_state_t;

  typedef struct packed {
    logic [CNT_W-1:0] rem;
    logic             ready;
  } sdrtg_tmr_st_t;

  typedef struct packed {
    sdrtg_state_t        st;
    logic [CLKRUN_W-1:0] clk_run;
    logic                unl_ok;
    logic                lck_ok;
    logic                cal_ok;
    logic                clk_stop_ok;
    logic                exit_ok;
    logic                path_off;
  } sdrtg_top_st_t;

endpackage : sdrtg_pkg

// [src/sdrtg_timer.sv]
// Down-counting interval timer with max-keep reload and registered ready flag
`timescale 1ns/1ns
module sdrtg_timer
  import sdrtg_pkg::*;
(
  input  wire logic             mclk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             load_in,
  input  wire logic [CNT_W-1:0] len_in,
  output logic                  ready_out
);
  import sdrtg_pkg::*;

  sdrtg_tmr_st_t q;
  sdrtg_tmr_st_t d;
  logic [CNT_W-1:0] adj;

  always_comb begin
    d   = q;
    adj = len_in - TMR_LOAD_ADJ;
    // A shorter new interval never cuts a longer one still running
    if (load_in && (adj >= q.rem)) begin
      d.rem = adj;
    end else if (q.rem != '0) begin
      d.rem = q.rem - 16'h0001;
    end
    d.ready = (d.rem == '0);
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '{rem: '0, ready: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign ready_out = q.ready;

endmodule : sdrtg_timer

// [src/sdrtg_guard.sv]
// Command-spacing guard for a DDR4 SDRAM around calibration and power states
// What this block does
// R1: Memory disables its command path mode-update plus path-disable delay after power-save entry.
// R2: Keep clock valid mode-update plus path-disable delay after power-save entry.
// R3: Supply valid clock the sleep-exit minimum before leaving power-save mode.
// R4: After power-save exit, unlocked commands wait the self-refresh exit interval.
// R5: After power-save exit, locked commands wait exit interval plus loop-lock interval.
// R6: After reset, allow 1024 cycles for initial calibration before commands.
// R7: Long calibration blocks all commands for 512 cycles.
// R8: Short calibration blocks all commands for 128 cycles.
// R9: After reset exit, wait max of 5 cycles and refresh time plus 10 ns.
// R10: After self-refresh exit, unlocked commands wait refresh time plus 10 ns.
// R11: With self-refresh abort, unlocked commands wait fine4 refresh time plus 10 ns.
// R12: Calibration and timing mode writes may follow exit after fine4 refresh plus 10 ns.
// R13: After self-refresh exit, locked commands wait the loop lock time.
// R14: Clock enable stays low in self-refresh pulse width plus one, plus parity latency.
// R15: Clock stays valid after sleep entry max(5 cycles,10 ns), plus parity latency.
// R16: Clock valid before sleep, power-down or reset exit max(5 cycles,10 ns); reset exit is not gated on clock_valid_in.
// R17: Mode update delay is max of 24 cycles and 15 ns.
// R18: Nanosecond terms round up to cycles; down-counters block gated command classes.
`timescale 1ns/1ns
module sdrtg_guard
  import sdrtg_pkg::*;
#(
  parameter int TRFC_NS   = 350,
  parameter int REFRESH_CYCLE_TIME_FINE4_NS  = 160,
  parameter int LOOP_LOCK_TIME_NCK = 768,
  parameter int PL_NCK    = 4
) (
  input  wire logic mclk_in,
  input  wire logic sys_rst_in,
  input  wire logic reset_exit_in,
  input  wire logic zq_init_in,
  input  wire logic long_impedance_cal_cmd_in,
  input  wire logic short_impedance_cal_cmd_in,
  input  wire logic sre_in,
  input  wire logic selfrefresh_exit_in,
  input  wire logic pde_in,
  input  wire logic pdx_in,
  input  wire logic max_power_saving_mode_enter_in,
  input  wire logic max_power_saving_mode_exit_in,
  input  wire logic clock_valid_in,
  input  wire logic parity_en_in,
  input  wire logic sr_abort_en_in,
  output logic      unlocked_cmd_ok_out,
  output logic      locked_cmd_ok_out,
  output logic      cal_mrs_cmd_ok_out,
  output logic      clock_stop_ok_out,
  output logic      cke_high_ok_out,
  output logic      cmd_path_disabled_out
);
  import sdrtg_pkg::*;

  // ****************************************************************
  // Interval lengths in cycles
  // ****************************************************************
  localparam int MODE_WRITE_UPDATE_DELAY = imax(MODE_WRITE_UPDATE_MIN_NCK,
                                                ns_to_nck(MODE_WRITE_UPDATE_MIN_NS)); // R17
  localparam int CMD_PATH_DISABLE_AFTER_POWER_SAVE =
      MODE_WRITE_UPDATE_DELAY + COMMAND_PASS_DISABLE_NCK;                          // R1
  localparam int SELFREFRESH_EXIT_TO_UNLOCKED_CMD =
      ns_to_nck(TRFC_NS + REFRESH_MARGIN_NS);                                       // R18
  localparam int SELFREFRESH_ABORT_EXIT_DELAY = ns_to_nck(REFRESH_CYCLE_TIME_FINE4_NS + REFRESH_MARGIN_NS);
  localparam int POWER_SAVE_EXIT_TO_LOCKED_CMD =
      SELFREFRESH_EXIT_TO_UNLOCKED_CMD + LOOP_LOCK_TIME_NCK;
  localparam int RESET_EXIT_TO_FIRST_CMD = imax(RESET_EXIT_MIN_NCK,
                                                SELFREFRESH_EXIT_TO_UNLOCKED_CMD);
  localparam int CLKEN_MIN_NCK = imax(CLKEN_PULSE_MIN_NCK, ns_to_nck(CLKEN_PULSE_MIN_NS));
  localparam int MIN_CLKEN_LOW_IN_SELFREFRESH = CLKEN_MIN_NCK + CLKEN_SELFREF_EXTRA_NCK;
  localparam int CLOCK_VALID_SLEEP = imax(CLOCK_VALID_MIN_NCK, ns_to_nck(CLOCK_VALID_MIN_NS));

  localparam logic [CLKRUN_W-1:0] CLKRUN_NEED = CLKRUN_W'(CLOCK_VALID_SLEEP);

  // Reuses the same readiness test for every command class
  function automatic logic all_ready(input logic [NUM_TMR-1:0] rdy,
                                     input logic [NUM_TMR-1:0] ld,
                                     input logic [NUM_TMR-1:0] mask);
    return &(~mask | (rdy & ~ld));
  endfunction : all_ready

  sdrtg_top_st_t    q;
  sdrtg_top_st_t    d;
  logic [NUM_TMR-1:0] rdy;
  logic [NUM_TMR-1:0] ld;
  logic [CNT_W-1:0]   len [NUM_TMR];

  // ****************************************************************
  // Timers
  // ****************************************************************
  for (genvar gi = 0; gi < NUM_TMR; gi++) begin : g_tmr
    sdrtg_timer u_tmr (
      .mclk_in    (mclk_in),
      .sys_rst_in (sys_rst_in),
      .load_in    (ld[gi]),
      .len_in     (len[gi]),
      .ready_out  (rdy[gi])
    );
  end

  always_comb begin
    ld = '0;
    for (int i = 0; i < NUM_TMR; i++) begin
      len[i] = '0;
    end
    // Controller issues one command per cycle, so the order only settles misuse
    if (zq_init_in) begin
      ld[TI_ANY]  = 1'b1;
      len[TI_ANY] = CNT_W'(INITIAL_IMPEDANCE_CAL_TIME);                             // R6
    end else if (long_impedance_cal_cmd_in) begin
      ld[TI_ANY]  = 1'b1;
      len[TI_ANY] = CNT_W'(LONG_IMPEDANCE_CAL_TIME);                                // R7
    end else if (short_impedance_cal_cmd_in) begin
      ld[TI_ANY]  = 1'b1;
      len[TI_ANY] = CNT_W'(SHORT_IMPEDANCE_CAL_TIME);                               // R8
    end else if (reset_exit_in) begin
      ld[TI_ANY]  = 1'b1;
      len[TI_ANY] = CNT_W'(RESET_EXIT_TO_FIRST_CMD);                                // R9
    end
    if (selfrefresh_exit_in) begin
      ld[TI_UNL]   = 1'b1;
      len[TI_UNL]  = sr_abort_en_in ? CNT_W'(SELFREFRESH_ABORT_EXIT_DELAY)          // R11
                                    : CNT_W'(SELFREFRESH_EXIT_TO_UNLOCKED_CMD);     // R10
      ld[TI_LCK]   = 1'b1;
      len[TI_LCK]  = CNT_W'(LOOP_LOCK_TIME_NCK);                                             // R13
      ld[TI_FAST]  = 1'b1;
      len[TI_FAST] = CNT_W'(SELFREFRESH_ABORT_EXIT_DELAY);                          // R12
    end else if (max_power_saving_mode_exit_in) begin
      ld[TI_UNL]   = 1'b1;
      len[TI_UNL]  = CNT_W'(SELFREFRESH_EXIT_TO_UNLOCKED_CMD);                      // R4
      ld[TI_LCK]   = 1'b1;
      len[TI_LCK]  = CNT_W'(POWER_SAVE_EXIT_TO_LOCKED_CMD);                         // R5
    end
    if (max_power_saving_mode_enter_in) begin
      ld[TI_CLKV]  = 1'b1;
      len[TI_CLKV] = CNT_W'(CMD_PATH_DISABLE_AFTER_POWER_SAVE);                     // R2
    end else if (sre_in || pde_in) begin
      ld[TI_CLKV]  = 1'b1;
      len[TI_CLKV] = parity_en_in ? CNT_W'(CLOCK_VALID_SLEEP + PL_NCK)
                                  : CNT_W'(CLOCK_VALID_SLEEP);                      // R15
    end
    if (sre_in) begin
      ld[TI_CKESR]  = 1'b1;
      len[TI_CKESR] = parity_en_in ? CNT_W'(MIN_CLKEN_LOW_IN_SELFREFRESH + PL_NCK)
                                   : CNT_W'(MIN_CLKEN_LOW_IN_SELFREFRESH);          // R14
    end
  end

  // ****************************************************************
  // Power state and gates
  // ****************************************************************
  always_comb begin
    d = q;
    if (reset_exit_in) begin
      d.st = ST_ACTIVE;
    end else begin
      unique case (q.st)
        ST_INIT: begin
          d.st = ST_INIT;
        end
        ST_ACTIVE: begin
          if (sre_in) begin
            d.st = ST_SELFREF;
          end else if (pde_in) begin
            d.st = ST_PWRDN;
          end else if (max_power_saving_mode_enter_in) begin
            d.st = ST_MAX_POWER_SAVING_MODE;
          end
        end
        ST_SELFREF: begin
          if (selfrefresh_exit_in) begin
            d.st = ST_ACTIVE;
          end
        end
        ST_PWRDN: begin
          if (pdx_in) begin
            d.st = ST_ACTIVE;
          end
        end
        ST_MAX_POWER_SAVING_MODE: begin
          if (max_power_saving_mode_exit_in) begin
            d.st = ST_ACTIVE;
          end
        end
      endcase
    end
    // Consecutive valid-clock cycles, saturating
    if (!clock_valid_in) begin
      d.clk_run = '0;
    end else if (q.clk_run < CLKRUN_NEED) begin
      d.clk_run = q.clk_run + 4'h1;
    end
    d.unl_ok = (d.st == ST_ACTIVE) &&
               all_ready(rdy, ld, NUM_TMR'((1 << TI_ANY) | (1 << TI_UNL)));     // R18
    d.lck_ok = d.unl_ok && all_ready(rdy, ld, NUM_TMR'(1 << TI_LCK));
    d.cal_ok = (d.st == ST_ACTIVE) &&
               all_ready(rdy, ld, NUM_TMR'((1 << TI_ANY) | (1 << TI_FAST)));    // R12
    d.clk_stop_ok = (d.st != ST_ACTIVE) && (d.st != ST_INIT) &&
                    all_ready(rdy, ld, NUM_TMR'(1 << TI_CLKV));                 // R15
    // Exit needs the low-width served and enough clock seen beforehand
    d.exit_ok = (d.st != ST_ACTIVE) && (d.st != ST_INIT) &&
                all_ready(rdy, ld, NUM_TMR'(1 << TI_CKESR)) &&
                (d.clk_run >= CLKRUN_NEED);                                      // R16 R3
    d.path_off = (d.st == ST_MAX_POWER_SAVING_MODE) && all_ready(rdy, ld, NUM_TMR'(1 << TI_CLKV)); // R1
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '{st: ST_INIT, clk_run: '0, default: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign unlocked_cmd_ok_out   = q.unl_ok;
  assign locked_cmd_ok_out     = q.lck_ok;
  assign cal_mrs_cmd_ok_out    = q.cal_ok;
  assign clock_stop_ok_out     = q.clk_stop_ok;
  assign cke_high_ok_out       = q.exit_ok;
  assign cmd_path_disabled_out = q.path_off;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [CNT_W-1:0] since_cal_q;
  logic [CNT_W-1:0] cal_len_q;
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      since_cal_q <= '0;
      cal_len_q   <= '0;
    end else if (ld[TI_ANY] && (17'(len[TI_ANY]) + 17'(since_cal_q) >= 17'(cal_len_q))) begin
      since_cal_q <= 16'h0001;
      cal_len_q   <= len[TI_ANY];
    end else if (since_cal_q != 16'hffff) begin
      since_cal_q <= since_cal_q + 16'h0001;
    end
  end

  property p_cal_gap;
    @(posedge mclk_in) disable iff (sys_rst_in)
      unlocked_cmd_ok_out |-> (since_cal_q >= cal_len_q);
  endproperty
  a_cal_gap: assert property (p_cal_gap) else $error("command allowed inside cal gap"); // R7

  property p_short_impedance_cal_cmd;
    @(posedge mclk_in) disable iff (sys_rst_in)
      short_impedance_cal_cmd_in |=> (!unlocked_cmd_ok_out && !cal_mrs_cmd_ok_out)[*8];
  endproperty
  a_short_impedance_cal_cmd: assert property (p_short_impedance_cal_cmd) else $error("short cal not blocking"); // R8

  property p_zqinit;
    @(posedge mclk_in) disable iff (sys_rst_in)
      zq_init_in |=> !unlocked_cmd_ok_out throughout (##8 1'b1);
  endproperty
  a_zqinit: assert property (p_zqinit) else $error("init cal not blocking"); // R6

  property p_xpr;
    @(posedge mclk_in) disable iff (sys_rst_in)
      reset_exit_in |=> (!unlocked_cmd_ok_out)[*5];
  endproperty
  a_xpr: assert property (p_xpr) else $error("command too soon after reset exit"); // R9

  property p_lock_implies_unl;
    @(posedge mclk_in) disable iff (sys_rst_in)
      locked_cmd_ok_out |-> unlocked_cmd_ok_out;
  endproperty
  a_lock_implies_unl: assert property (p_lock_implies_unl) else $error("locked too early"); // R5

  property p_srx_lock;
    @(posedge mclk_in) disable iff (sys_rst_in)
      selfrefresh_exit_in |=> (!locked_cmd_ok_out && !unlocked_cmd_ok_out)[*8];
  endproperty
  a_srx_lock: assert property (p_srx_lock) else $error("command too soon after exit"); // R13

  property p_ckesr;
    @(posedge mclk_in) disable iff (sys_rst_in)
      sre_in |=> (!cke_high_ok_out)[*3];
  endproperty
  a_ckesr: assert property (p_ckesr) else $error("clock enable low too short"); // R14

  property p_cksre;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (sre_in || pde_in) |=> (!clock_stop_ok_out)[*4];
  endproperty
  a_cksre: assert property (p_cksre) else $error("clock stop too early"); // R15

  property p_max_power_saving_mode_clk;
    @(posedge mclk_in) disable iff (sys_rst_in)
      max_power_saving_mode_enter_in |=> (!clock_stop_ok_out && !cmd_path_disabled_out)[*8];
  endproperty
  a_max_power_saving_mode_clk: assert property (p_max_power_saving_mode_clk) else $error("power save clock stop too early"); // R2

  property p_cksrx;
    @(posedge mclk_in) disable iff (sys_rst_in)
      cke_high_ok_out |-> $past(clock_valid_in, 1) && $past(clock_valid_in, 5);
  endproperty
  a_cksrx: assert property (p_cksrx) else $error("exit without valid clock"); // R16

  c_long_impedance_cal_cmd: cover property (@(posedge mclk_in) disable iff (sys_rst_in)
    long_impedance_cal_cmd_in ##[1:600] unlocked_cmd_ok_out);
  c_srx: cover property (@(posedge mclk_in) disable iff (sys_rst_in)
    selfrefresh_exit_in ##[1:1000] locked_cmd_ok_out);
  c_max_power_saving_mode: cover property (@(posedge mclk_in) disable iff (sys_rst_in)
    max_power_saving_mode_enter_in ##[1:100] cmd_path_disabled_out);
  c_exit: cover property (@(posedge mclk_in) disable iff (sys_rst_in)
    sre_in ##[1:100] cke_high_ok_out);

endmodule : sdrtg_guard

// [dv/sdrtg_dram_model.sv]
// Behavioural model of the memory's command path around maximum power saving mode
`timescale 1ns/1ns
module sdrtg_dram_model (
  input  wire logic mclk_in,
  input  wire logic sys_rst_in,
  input  wire logic max_power_saving_mode_enter_in,
  input  wire logic max_power_saving_mode_exit_in,
  output logic      cmd_path_off_out
);
  // Update delay is 24 cycles: 15 ns is only 2 cycles at 8 ns
  localparam int MODE_DLY = 24;
  localparam int PATH_DLY = MODE_DLY + 4;

  logic [7:0] cnt_q;
  logic       in_save_q;

  // Counter saturates so a long stay never wraps back below the threshold
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_q     <= 8'h00;
      in_save_q <= 1'b0;
    end else if (max_power_saving_mode_enter_in) begin
      // Holds the cycle index after entry, so the entry edge starts cycle one
      cnt_q     <= 8'h01;
      in_save_q <= 1'b1;
    end else if (max_power_saving_mode_exit_in) begin
      in_save_q <= 1'b0;
    end else if (in_save_q && cnt_q != 8'hff) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign cmd_path_off_out = in_save_q && (cnt_q >= 8'(PATH_DLY));
endmodule : sdrtg_dram_model

// [dv/sdrtg_guard_tb_top.sv]
// Self-checking testbench of the SDRAM power-state timing guard
`timescale 1ns/1ns
module sdrtg_guard_tb_top;
  logic       mclk_in;
  logic       sys_rst_in;
  logic [9:0] ev;
  logic       clock_valid_in;
  logic       parity_en_in;
  logic       sr_abort_en_in;
  wire  [5:0] ok;
  wire        model_off;
  int         mismatches;
  int         tests_run;

  // Lock time shortened so the locked-loop waits stay brief
  sdrtg_guard #(.LOOP_LOCK_TIME_NCK(60)) sdrtg_guard_i (
    .mclk_in                        (mclk_in),
    .sys_rst_in                     (sys_rst_in),
    .reset_exit_in                  (ev[0]),
    .zq_init_in                     (ev[1]),
    .long_impedance_cal_cmd_in      (ev[2]),
    .short_impedance_cal_cmd_in     (ev[3]),
    .sre_in                         (ev[4]),
    .selfrefresh_exit_in            (ev[5]),
    .pde_in                         (ev[6]),
    .pdx_in                         (ev[7]),
    .max_power_saving_mode_enter_in (ev[8]),
    .max_power_saving_mode_exit_in  (ev[9]),
    .clock_valid_in                 (clock_valid_in),
    .parity_en_in                   (parity_en_in),
    .sr_abort_en_in                 (sr_abort_en_in),
    .unlocked_cmd_ok_out            (ok[0]),
    .locked_cmd_ok_out              (ok[1]),
    .cal_mrs_cmd_ok_out             (ok[2]),
    .clock_stop_ok_out              (ok[3]),
    .cke_high_ok_out                (ok[4]),
    .cmd_path_disabled_out          (ok[5])
  );

  sdrtg_dram_model sdrtg_dram_model_i (
    .mclk_in                        (mclk_in),
    .sys_rst_in                     (sys_rst_in),
    .max_power_saving_mode_enter_in (ev[8]),
    .max_power_saving_mode_exit_in  (ev[9]),
    .cmd_path_off_out               (model_off)
  );

  initial mclk_in = 1'b0;
  always #4 mclk_in = ~mclk_in;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t ns: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // Event is taken on the second edge; returns just after it
  task automatic fire(input int i);
    @(posedge mclk_in);
    #1 ev[i] = 1'b1;
    @(posedge mclk_in);
    #1 ev[i] = 1'b0;
  endtask : fire

  // Entered in cycle 1 after the event: low at cycles 1 and n-1, high at cycle n
  task automatic expect_rise(input int o, input int n);
    chk(16'(ok[o]), 16'h0000);
    for (int k = 2; k <= n; k++) begin
      @(posedge mclk_in);
      #1;
      if (k == n - 1) chk(16'(ok[o]), 16'h0000);
    end
    chk(16'(ok[o]), 16'h0001);
  endtask : expect_rise

  // Clock stops, then must run five cycles before exit is allowed again
  task automatic clk_gap;
    int w;
    clock_valid_in = 1'b0;
    repeat (3) @(posedge mclk_in);
    #1 chk(16'(ok[4]), 16'h0000);
    clock_valid_in = 1'b1;
    repeat (4) @(posedge mclk_in);
    #1 chk(16'(ok[4]), 16'h0000);
    w = 0;
    while (ok[4] !== 1'b1 && w < 4) begin
      @(posedge mclk_in);
      #1 w++;
    end
    chk(16'(ok[4]), 16'h0001);
  endtask : clk_gap

  task automatic cmp_model(input int n);
    repeat (n) begin
      @(posedge mclk_in);
      #1 chk(16'(ok[5]), 16'(model_off));
    end
  endtask : cmp_model

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic s_reset_exit;
    fire(0);
    expect_rise(0, 45);
  endtask : s_reset_exit

  // Long then short two cycles later: the short reload must not cut the long wait
  task automatic s_cal;
    fire(1);
    expect_rise(0, 1024);
    fire(2);
    fire(3);
    expect_rise(0, 510);
    fire(3);
    fork
      expect_rise(0, 128);
      expect_rise(2, 128);
    join
  endtask : s_cal

  task automatic s_sref(input logic par, input logic abrt);
    parity_en_in   = par;
    sr_abort_en_in = abrt;
    fire(4);
    fork
      expect_rise(3, par ? 9 : 5);
      expect_rise(4, par ? 8 : 4);
    join
    fire(5);
    fork
      expect_rise(0, abrt ? 22 : 45);
      expect_rise(2, 22);
      expect_rise(1, 60);
    join
    parity_en_in   = 1'b0;
    sr_abort_en_in = 1'b0;
  endtask : s_sref

  task automatic s_pd;
    fire(6);
    expect_rise(3, 5);
    clk_gap();
    fire(7);
    chk(16'(ok[4]), 16'h0000);
    chk(16'(ok[3]), 16'h0000);
  endtask : s_pd

  task automatic s_max_power_saving_mode;
    fire(8);
    fork
      expect_rise(5, 28);
      expect_rise(3, 28);
      cmp_model(30);
    join
    clk_gap();
    fire(9);
    fork
      expect_rise(0, 45);
      expect_rise(1, 105);
    join
    chk(16'(ok[5]), 16'(model_off));
  endtask : s_max_power_saving_mode

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    mismatches     = 0;
    tests_run      = 0;
    sys_rst_in     = 1'b1;
    ev             = 10'h000;
    clock_valid_in = 1'b1;
    parity_en_in   = 1'b0;
    sr_abort_en_in = 1'b0;
    repeat (6) @(posedge mclk_in);
    #1 sys_rst_in = 1'b0;
    chk(16'(ok), 16'h0000);
    @(posedge mclk_in);
    #1 chk(16'(ok), 16'h0000);
    s_reset_exit();
    s_cal();
    s_sref(1'b0, 1'b0);
    s_sref(1'b1, 1'b1);
    s_pd();
    s_max_power_saving_mode();
    test_done();
  end

  // The full run needs under 3,000 cycles
  initial begin
    repeat (20000) @(posedge mclk_in);
    mismatches++;
    test_done();
  end
endmodule : sdrtg_guard_tb_top
